//--- verilog/usb_endpoint_status_control.sv
// Endpoint status flags and handshake decisions for a low-speed function
`include "usb_ep_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module usb_endpoint_status_control (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic line_bus_reset,
  input wire logic line_eop,
  input wire logic line_activity,
  input wire usb_ep_pkg::token_s token,
  input wire logic ep0_tx_acked,
  input wire logic ep0_rx_acked,
  input wire logic ep12_tx_acked,
  output usb_ep_pkg::reply_s reply,
  output logic usb_clock_gate,
  output logic internal_reset
);

  // ----------------------------------------------------------------
  // Line synchronisers
  // ----------------------------------------------------------------
  // Line events come from the transceiver domain; two stages each
  logic [2:0] line_meta_reg;
  logic [2:0] line_sync_reg;
  logic eop_seen_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      line_meta_reg <= 3'h0;
      line_sync_reg <= 3'h0;
    end else begin
      line_meta_reg <= {line_activity, line_eop, line_bus_reset};
      line_sync_reg <= line_meta_reg;
    end
  end

  // EOP is a level on the lines; set the flag once per occurrence
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      eop_seen_reg <= 1'b0;
    end else begin
      eop_seen_reg <= line_sync_reg[1];
    end
  end

  logic bus_reset_seen;
  logic eop_rise;
  logic activity_seen;
  assign bus_reset_seen = line_sync_reg[0];
  assign eop_rise = line_sync_reg[1] & ~eop_seen_reg;
  assign activity_seen = line_sync_reg[2];

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  logic wr_status;
  logic wr_enable;
  logic wr_ep0;
  logic wr_ep12;
  assign wr_status = reg_write && (reg_addr == `ADDR_EVENT_STATUS);
  assign wr_enable = reg_write && (reg_addr == `ADDR_EVENT_ENABLE);
  assign wr_ep0 = reg_write && (reg_addr == `ADDR_EP0_TX_CTRL);
  assign wr_ep12 = reg_write && (reg_addr == `ADDR_EP12_TX_CTRL);

  logic [7:0] event_enable_reg;
  logic [7:0] ep0_tx_control_reg;
  logic [7:0] ep12_tx_control_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      event_enable_reg <= `REG_RESET;
    end else if (wr_enable) begin
      event_enable_reg <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ep12_tx_control_reg <= `REG_RESET;
    end else if (wr_ep12) begin
      ep12_tx_control_reg <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Endpoint-0 control
  // ----------------------------------------------------------------
  logic setup_seen;
  assign setup_seen = token.valid && (token.kind == usb_ep_pkg::TOK_SETUP)
    && (token.endpoint == 2'h0);

  // Sequence, enables and byte count are firmware-owned
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ep0_tx_control_reg <= `REG_RESET;
    end else begin
      if (wr_ep0) begin
        ep0_tx_control_reg <= reg_wdata;
      end
      // SETUP must always get through, so it beats a firmware write
      if (setup_seen) begin
        ep0_tx_control_reg[`C0_STALL] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event status flags
  // ----------------------------------------------------------------
  logic suspend_flag_reg;
  logic resume_flag_reg;
  logic bus_reset_flag_reg;
  logic ep0_tx_done_flag_reg;
  logic ep0_rx_done_flag_reg;
  logic ep12_tx_done_flag_reg;
  logic end_of_packet_flag_reg;

  // Suspend is set and cleared by firmware only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      suspend_flag_reg <= 1'b0;
    end else if (wr_status) begin
      suspend_flag_reg <= reg_wdata[`ST_SUSPEND];
    end
  end

  // Read-only; follows the reset state on the lines
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_reset_flag_reg <= 1'b0;
    end else begin
      bus_reset_flag_reg <= bus_reset_seen;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ep0_tx_done_flag_reg <= 1'b0;
    end else if (ep0_tx_acked) begin
      ep0_tx_done_flag_reg <= 1'b1;
    end else if (wr_status && !reg_wdata[`ST_EP0_TX_DONE]) begin
      ep0_tx_done_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ep0_rx_done_flag_reg <= 1'b0;
    end else if (ep0_rx_acked) begin
      ep0_rx_done_flag_reg <= 1'b1;
    end else if (wr_status && !reg_wdata[`ST_EP0_RX_DONE]) begin
      ep0_rx_done_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ep12_tx_done_flag_reg <= 1'b0;
    end else if (ep12_tx_acked) begin
      ep12_tx_done_flag_reg <= 1'b1;
    end else if (wr_status && !reg_wdata[`ST_EP12_TX_DONE]) begin
      ep12_tx_done_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      end_of_packet_flag_reg <= 1'b0;
    end else if (eop_rise) begin
      end_of_packet_flag_reg <= 1'b1;
    end else if (wr_status && !reg_wdata[`ST_EOP]) begin
      end_of_packet_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resume_flag_reg <= 1'b0;
    end else if (activity_seen && suspend_flag_reg) begin
      resume_flag_reg <= 1'b1;
    end else if (wr_status && !reg_wdata[`ST_RESUME]) begin
      resume_flag_reg <= 1'b0;
    end
  end

  logic [7:0] status_view;
  assign status_view = {suspend_flag_reg, 1'b0, bus_reset_flag_reg,
    ep0_tx_done_flag_reg, ep0_rx_done_flag_reg, ep12_tx_done_flag_reg,
    end_of_packet_flag_reg, resume_flag_reg};

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        `ADDR_EVENT_STATUS: reg_rdata <= status_view;
        `ADDR_EVENT_ENABLE: reg_rdata <= event_enable_reg;
        `ADDR_EP0_TX_CTRL: reg_rdata <= ep0_tx_control_reg;
        `ADDR_EP12_TX_CTRL: reg_rdata <= ep12_tx_control_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Suspend and internal reset outputs
  // ----------------------------------------------------------------
  // Gate is held while suspended; the clock stops outside this block
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      usb_clock_gate <= 1'b0;
    end else begin
      usb_clock_gate <= suspend_flag_reg;
    end
  end

  // Not used inside this block; lasts as long as the line state while EN_BUS_RESET is set
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      internal_reset <= 1'b0;
    end else begin
      internal_reset <= bus_reset_seen
        && event_enable_reg[`EN_BUS_RESET];
    end
  end

  // ----------------------------------------------------------------
  // Handshake decision
  // ----------------------------------------------------------------
  usb_ep_pkg::reply_s reply_next;

  always_comb begin
    reply_next = '0;
    reply_next.valid = token.valid;
    reply_next.kind = usb_ep_pkg::HS_NONE;
    reply_next.data_pid_one = ep0_tx_control_reg[`C0_SEQ];
    reply_next.byte_count = ep0_tx_control_reg[3:0];
    if (token.valid && token.endpoint == 2'h0) begin
      if (token.kind == usb_ep_pkg::TOK_SETUP) begin
        reply_next.kind = usb_ep_pkg::HS_ACK;
      end else if (ep0_tx_control_reg[`C0_STALL] &&
          (token.kind == usb_ep_pkg::TOK_IN ||
           token.kind == usb_ep_pkg::TOK_OUT)) begin
        reply_next.kind = usb_ep_pkg::HS_STALL;
      end else if (token.kind == usb_ep_pkg::TOK_IN) begin
        if (!ep0_tx_control_reg[`C0_TX_EN] || ep0_tx_done_flag_reg) begin
          reply_next.kind = usb_ep_pkg::HS_NAK;
        end else begin
          reply_next.kind = usb_ep_pkg::HS_ACK;
        end
      end else if (token.kind == usb_ep_pkg::TOK_OUT) begin
        if (!ep0_tx_control_reg[`C0_RX_EN] || ep0_rx_done_flag_reg) begin
          reply_next.kind = usb_ep_pkg::HS_NAK;
        end else begin
          reply_next.kind = usb_ep_pkg::HS_ACK;
        end
      end
    end else if (token.valid && token.kind == usb_ep_pkg::TOK_IN) begin
      if (!ep12_tx_control_reg[`C1_TX_EN] || ep12_tx_done_flag_reg) begin
        reply_next.kind = usb_ep_pkg::HS_NAK;
      end else begin
        reply_next.kind = usb_ep_pkg::HS_ACK;
      end
      reply_next.byte_count = ep12_tx_control_reg[3:0];
      reply_next.data_pid_one = ep12_tx_control_reg[7];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reply <= '0;
    end else begin
      reply <= reply_next;
    end
  end

endmodule // usb_endpoint_status_control

`default_nettype wire

//--- verilog/usb_ep_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef USB_EP_DEFS_SVH
`define USB_EP_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_EVENT_ENABLE 8'he9
`define ADDR_EVENT_STATUS 8'he8
`define ADDR_EP0_TX_CTRL 8'hea
`define ADDR_EP12_TX_CTRL 8'heb

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define ST_SUSPEND 7
`define ST_BUS_RESET 5
`define ST_EP0_TX_DONE 4
`define ST_EP0_RX_DONE 3
`define ST_EP12_TX_DONE 2
`define ST_EOP 1
`define ST_RESUME 0

// ----------------------------------------------------------------
// Control bit positions
// ----------------------------------------------------------------
`define EN_BUS_RESET 6
`define C0_SEQ 7
`define C0_STALL 6
`define C0_TX_EN 5
`define C0_RX_EN 4
`define C1_TX_EN 5

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define REG_RESET 8'h00
`define IDLE_SUSPEND_US 3000
`define CLK_MHZ 40
`define IDLE_SUSPEND_CYCLES (`IDLE_SUSPEND_US * `CLK_MHZ)

`endif

//--- verilog/usb_ep_pkg.sv
// Types shared by the endpoint status and control logic
package usb_ep_pkg;

  typedef enum logic [1:0] {
    HS_NONE,
    HS_ACK,
    HS_NAK,
    HS_STALL
  } handshake_e;

  typedef enum logic [1:0] {
    TOK_IN,
    TOK_OUT,
    TOK_SETUP,
    TOK_OTHER
  } token_e;

  typedef struct packed {
    logic valid;
    token_e kind;
    logic [1:0] endpoint;
  } token_s;

  typedef struct packed {
    logic valid;
    handshake_e kind;
    logic data_pid_one;
    logic [3:0] byte_count;
  } reply_s;

endpackage

//--- testbench/usb_host_model.sv
// Behavioural host controller and line model for the endpoint block
`timescale 1ns/100ps
`default_nettype none

module usb_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire usb_ep_pkg::reply_s reply,
  output usb_ep_pkg::token_s token,
  output logic line_bus_reset,
  output logic line_eop,
  output logic line_activity,
  output logic [2:0] acked
);
  // --------------------------------
  // Token, handshake and line drive
  // --------------------------------
  // Idle bus while the bench holds reset; tasks drive it afterwards
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      token <= '0;
      acked <= 3'h0;
      {line_bus_reset, line_eop, line_activity} <= 3'h0;
    end
  end

  // Reply is taken one cycle after the token edge, where it stands
  task automatic send(input usb_ep_pkg::token_e k, input logic [1:0] ep,
                      output usb_ep_pkg::reply_s r);
    @(posedge sys_clk);
    token <= '{1'b1, k, ep};
    @(posedge sys_clk);
    token <= '0;
    #1 r = reply;
  endtask

  // Bit 0 ep0 sent, bit 1 ep0 received, bit 2 ep1/2 sent
  task automatic ack(input int b);
    @(posedge sys_clk);
    acked[b] <= 1'b1;
    @(posedge sys_clk);
    acked[b] <= 1'b0;
  endtask

  // Levels: bus reset, end of packet, activity
  task automatic lines(input logic [2:0] v);
    @(posedge sys_clk);
    {line_bus_reset, line_eop, line_activity} <= v;
  endtask
endmodule // usb_host_model
`default_nettype wire

//--- testbench/usb_ep_assertions.sv
// Port assertions for the endpoint status and control block
`include "usb_ep_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module usb_ep_assertions (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic line_bus_reset,
  input wire usb_ep_pkg::token_s token,
  input wire logic ep0_tx_acked,
  input wire usb_ep_pkg::reply_s reply,
  input wire logic usb_clock_gate,
  input wire logic internal_reset
);
  // --------------------------------
  // Shadow of ep0 control and done
  // --------------------------------
  // Rebuilt from port traffic, since the body is hidden from us
  logic [7:0] ctl_reg;
  logic txd_reg;
  logic setup0;
  logic st_wr;
  assign setup0 = token.valid && token.kind == usb_ep_pkg::TOK_SETUP
    && token.endpoint == 2'h0;
  assign st_wr = reg_write && reg_addr == `ADDR_EVENT_STATUS;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_reg <= 8'h00;
      txd_reg <= 1'b0;
    end else begin
      if (reg_write && reg_addr == `ADDR_EP0_TX_CTRL)
        ctl_reg <= {reg_wdata[7], reg_wdata[6] && !setup0, reg_wdata[5:0]};
      else if (setup0)
        ctl_reg[6] <= 1'b0;
      if (ep0_tx_acked)
        txd_reg <= 1'b1;
      else if (st_wr)
        txd_reg <= txd_reg && reg_wdata[4];
    end
  end

  sequence s_in0;
    token.valid && token.kind == usb_ep_pkg::TOK_IN && token.endpoint == 2'h0;
  endsequence
  sequence s_out0;
    token.valid && token.kind == usb_ep_pkg::TOK_OUT && token.endpoint == 2'h0;
  endsequence
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_stall_in_out: assert property (
    (s_in0 or s_out0) ##0 ctl_reg[6] |=> reply.kind == usb_ep_pkg::HS_STALL)
    else $error("stall bit did not stall");
  a_in_nak_off: assert property (
    s_in0 ##0 ctl_reg[6:5] == 2'b00 |=> reply.kind == usb_ep_pkg::HS_NAK)
    else $error("disabled IN not refused");
  a_in_nak_done: assert property (
    s_in0 ##0 (!ctl_reg[6] && txd_reg) |=> reply.kind == usb_ep_pkg::HS_NAK)
    else $error("IN with done flag not refused");
  a_out_nak_off: assert property (
    s_out0 ##0 {ctl_reg[6], ctl_reg[4]} == 2'b00
    |=> reply.kind == usb_ep_pkg::HS_NAK) else $error("OUT not refused");
  a_in_pid_count: assert property (
    s_in0 ##0 (ctl_reg[6:5] == 2'b01 && !txd_reg) |=> reply.data_pid_one
    == ctl_reg[7] && reply.byte_count == ctl_reg[3:0]) else $error("bad IN");
  a_ctl_readback: assert property (
    reg_read && reg_addr == `ADDR_EP0_TX_CTRL |=> reg_rdata == $past(ctl_reg))
    else $error("control readback wrong");
  a_gate_on: assert property (st_wr && reg_wdata[7] |-> ##2 usb_clock_gate)
    else $error("gate not raised");
  a_gate_off: assert property (st_wr && !reg_wdata[7] |-> ##2 !usb_clock_gate)
    else $error("gate not lowered");
  a_int_reset_cause: assert property (
    internal_reset |-> $past(line_bus_reset, 3) || $past(line_bus_reset, 4))
    else $error("internal reset without bus reset");
endmodule // usb_ep_assertions

bind usb_endpoint_status_control usb_ep_assertions usb_ep_assertions_i (
  .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .line_bus_reset(line_bus_reset), .token(token),
  .ep0_tx_acked(ep0_tx_acked), .reply(reply),
  .usb_clock_gate(usb_clock_gate), .internal_reset(internal_reset)
);
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the endpoint status and control block
`include "usb_ep_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // --------------------------------
  // Harness
  // --------------------------------
  localparam logic [7:0] st = `ADDR_EVENT_STATUS;
  localparam logic [7:0] en = `ADDR_EVENT_ENABLE;
  localparam logic [7:0] ctl = `ADDR_EP0_TX_CTRL;
  logic sys_clk, rst, reg_write, reg_read;
  logic [7:0] reg_addr, reg_wdata;
  wire logic [7:0] reg_rdata;
  wire logic usb_clock_gate, internal_reset, lbr, leop, lact;
  wire logic [2:0] acked;
  wire usb_ep_pkg::token_s token;
  wire usb_ep_pkg::reply_s reply;
  usb_ep_pkg::reply_s r;
  int fail_count, samples_checked;

  usb_endpoint_status_control usb_endpoint_status_control_i (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .line_bus_reset(lbr), .line_eop(leop), .line_activity(lact),
    .token(token), .ep0_tx_acked(acked[0]), .ep0_rx_acked(acked[1]),
    .ep12_tx_acked(acked[2]), .reply(reply), .usb_clock_gate(usb_clock_gate),
    .internal_reset(internal_reset));
  usb_host_model usb_host_model_i (.sys_clk(sys_clk), .rst(rst), .reply(reply),
    .token(token), .line_bus_reset(lbr), .line_eop(leop),
    .line_activity(lact), .acked(acked));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic results;
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // s=1 expects handshake h, s=0 expects anything but h
  task automatic tk(input usb_ep_pkg::token_e k, input logic [1:0] ep,
                    input usb_ep_pkg::handshake_e h, input logic s);
    usb_host_model_i.send(k, ep, r);
    chk({6'h00, r.valid, r.kind === h}, {6'h00, 1'b1, s});
  endtask

  // Bounded wait on gate (w=0) or internal reset (w=1)
  task automatic wait_hi(input logic w);
    int i;
    for (i = 0; i < 16 && (w ? internal_reset : usb_clock_gate) !== 1'b1; i++)
      @(posedge sys_clk);
    if (i == 16) begin
      fail_count++;
      $display("ERROR %0t: wait timed out", $time);
      results();
    end
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_reset_values;
    rd(st, 8'h00);
    rd(ctl, 8'h00);
    rd(en, 8'h00);
    rd(8'h00, 8'h00);
  endtask

  task automatic t_stall_and_nak;
    tk(usb_ep_pkg::TOK_IN, 2'h0, usb_ep_pkg::HS_NAK, 1'b1);
    tk(usb_ep_pkg::TOK_OUT, 2'h0, usb_ep_pkg::HS_NAK, 1'b1);
    wr(ctl, 8'h40);
    tk(usb_ep_pkg::TOK_IN, 2'h0, usb_ep_pkg::HS_STALL, 1'b1);
    tk(usb_ep_pkg::TOK_OUT, 2'h0, usb_ep_pkg::HS_STALL, 1'b1);
    tk(usb_ep_pkg::TOK_SETUP, 2'h0, usb_ep_pkg::HS_STALL, 1'b0);
    rd(ctl, 8'h00);
  endtask

  task automatic t_ep0_tx;
    wr(ctl, 8'hb5);
    tk(usb_ep_pkg::TOK_IN, 2'h0, usb_ep_pkg::HS_NAK, 1'b0);
    chk({3'h0, r.data_pid_one, r.byte_count}, 8'h15);
    rd(st, 8'h00);
    // Hardware set lands on the same edge as the clearing write
    fork
      wr(st, 8'h00);
      usb_host_model_i.ack(0);
    join
    rd(st, 8'h10);
    tk(usb_ep_pkg::TOK_IN, 2'h0, usb_ep_pkg::HS_NAK, 1'b1);
    wr(st, 8'h00);
    rd(st, 8'h00);
    rd(ctl, 8'hb5);
  endtask

  task automatic t_rx_and_ep12;
    wr(ctl, 8'h10);
    tk(usb_ep_pkg::TOK_OUT, 2'h0, usb_ep_pkg::HS_NAK, 1'b0);
    usb_host_model_i.ack(1);
    rd(st, 8'h08);
    tk(usb_ep_pkg::TOK_OUT, 2'h0, usb_ep_pkg::HS_NAK, 1'b1);
    wr(`ADDR_EP12_TX_CTRL, 8'h20);
    tk(usb_ep_pkg::TOK_IN, 2'h1, usb_ep_pkg::HS_NAK, 1'b0);
    usb_host_model_i.ack(2);
    rd(st, 8'h0c);
    tk(usb_ep_pkg::TOK_IN, 2'h2, usb_ep_pkg::HS_NAK, 1'b1);
    wr(st, 8'h00);
  endtask

  task automatic t_eop_suspend;
    usb_host_model_i.lines(3'b010);
    usb_host_model_i.lines(3'b000);
    repeat (5) @(posedge sys_clk);
    rd(st, 8'h02);
    rd(st, 8'h02);
    wr(st, 8'h82);
    wait_hi(1'b0);
    chk({7'h00, usb_clock_gate}, 8'h01);
    usb_host_model_i.lines(3'b001);
    repeat (6) @(posedge sys_clk);
    usb_host_model_i.lines(3'b000);
    rd(st, 8'h83);
    wr(st, 8'h00);
    repeat (3) @(posedge sys_clk);
    chk({7'h00, usb_clock_gate}, 8'h00);
  endtask

  task automatic t_bus_reset;
    usb_host_model_i.lines(3'b100);
    repeat (6) @(posedge sys_clk);
    chk({7'h00, internal_reset}, 8'h00);
    wr(st, 8'h00);
    rd(st, 8'h20);
    usb_host_model_i.lines(3'b000);
    wr(en, 8'h40);
    rd(en, 8'h40);
    usb_host_model_i.lines(3'b100);
    wait_hi(1'b1);
    chk({7'h00, internal_reset}, 8'h01);
    usb_host_model_i.lines(3'b000);
  endtask

  initial begin
    rst = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset_values();
    t_stall_and_nak();
    t_ep0_tx();
    t_rx_and_ep12();
    t_eop_suspend();
    t_bus_reset();
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    rd(en, 8'h00);
    results();
  end
endmodule // tb_top
`default_nettype wire
